// ---- core/pcc_defines.vh ----
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// Register addresses on the special-function register port.
`define PCC_CFG_ADDR 8'ha1
`define PCC_LOW_BASE 8'hf0
`define PCC_HIGH_BASE 8'hf1
`define PCC_SLOT_STRIDE 8'h02

// Field positions inside the PWM configuration register.
`define PCC_BIT_BANK_SEL 7
`define PCC_BIT_IRQ_EN 6
`define PCC_BIT_FLAG 5
`define PCC_LEN_MSB 1
`define PCC_LEN_LSB 0

// Reset values and fixed read values.
`define PCC_CFG_RESET 8'h00
`define PCC_UNUSED_READ 3'h0
`define PCC_BYTE_ZERO 8'h00
`define PCC_WORD_RESET 16'h0000

// Cycle length select codes.
`define PCC_LEN_8 2'h0
`define PCC_LEN_9 2'h1
`define PCC_LEN_10 2'h2
`define PCC_LEN_11 2'h3

// Counter period tops for each cycle length and for 16-bit channels.
`define PCC_TOP_8 16'h00ff
`define PCC_TOP_9 16'h01ff
`define PCC_TOP_10 16'h03ff
`define PCC_TOP_11 16'h07ff
`define PCC_TOP_16 16'hffff

// Lowest and highest counter bit watched for a cycle overflow.
`define PCC_WATCH_LSB 7
`define PCC_WATCH_MSB 10

// Number of capture/compare modules served.
`define PCC_SLOTS 3

`endif

// ---- core/pcc_reload_slot.v ----
`timescale 1ns/10ps
`default_nettype none
`include "pcc_defines.vh"

// One module's compare value and its auto-reload shadow. Software bytes
// land in one or the other depending on the bank select; the shadow is
// copied into the compare value only when the parent asks at a cycle end.
module pcc_reload_slot (
    input wire clock,
    input wire reset,
    input wire writeLow,
    input wire writeHigh,
    input wire bankSel,
    input wire [7:0] writeData,
    input wire reloadNow,
    output reg [15:0] compareValue,
    output reg [15:0] reloadValue
);

    reg [15:0] next_compareValue;
    reg [15:0] next_reloadValue;

    always @* begin
        next_compareValue = compareValue;
        next_reloadValue = reloadValue;
        // A software write in the same cycle as a reload wins on the byte
        // it touches, so the newest duty value is never overwritten.
        if (reloadNow) begin
            next_compareValue = reloadValue;
        end
        if (writeLow && !bankSel) begin
            next_compareValue[7:0] = writeData;
        end
        if (writeHigh && !bankSel) begin
            next_compareValue[15:8] = writeData;
        end
        if (writeLow && bankSel) begin
            next_reloadValue[7:0] = writeData;
        end
        if (writeHigh && bankSel) begin
            next_reloadValue[15:8] = writeData;
        end
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            compareValue <= `PCC_WORD_RESET;
            reloadValue <= `PCC_WORD_RESET;
        end else begin
            compareValue <= next_compareValue;
            reloadValue <= next_reloadValue;
        end
    end

endmodule

`default_nettype wire

// ---- core/pcc_cycle_config.v ----
`timescale 1ns/10ps
`default_nettype none
`include "pcc_defines.vh"

module pcc_cycle_config (
    input wire clock,
    input wire reset,
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire sfrRead,
    input wire [7:0] sfrWriteData,
    output reg [7:0] sfrReadData,
    input wire [15:0] counterValue,
    input wire [2:0] pwmEnable,
    input wire [2:0] widePwmEnable,
    output wire [47:0] compareValues,
    output reg [47:0] cycleTops,
    output reg cycleOverflowFlag,
    output reg cycleOverflowPulse,
    output reg irqRequest
);

    // Returns 1 when addr selects the given slot within a byte bank.
    function slotHit;
        input [7:0] addr;
        input [7:0] base;
        input [1:0] slot;
        reg [7:0] offset;
        begin
            offset = base + {6'h00, slot} * `PCC_SLOT_STRIDE;
            slotHit = (addr == offset);
        end
    endfunction

    // Counter period top for the selected non-16-bit cycle length.
    function [15:0] lengthTop;
        input [1:0] sel;
        begin
            case (sel)
                `PCC_LEN_8: lengthTop = `PCC_TOP_8;
                `PCC_LEN_9: lengthTop = `PCC_TOP_9;
                `PCC_LEN_10: lengthTop = `PCC_TOP_10;
                `PCC_LEN_11: lengthTop = `PCC_TOP_11;
                default: lengthTop = `PCC_TOP_8;
            endcase
        end
    endfunction

    reg reloadBankSelect;
    reg cycleOverflowIrqEnable;
    reg [1:0] cycleLengthSelect;
    reg [3:0] watchedBitsPrev;

    wire cfgHit;
    wire cfgWrite;
    wire [3:0] watchedBits;
    wire [3:0] watchedFalls;
    wire cycleWrap;
    wire [7:0] cfgReadValue;
    wire [47:0] reloadValues;
    wire [2:0] lowHits;
    wire [2:0] highHits;
    wire [2:0] reloadNow;

    reg next_flag;
    reg [7:0] next_readData;
    reg [47:0] next_cycleTops;
    integer i;
    // Separate loop indices keep each combinational process sole driver.
    integer j;

    assign cfgHit = (sfrAddr == `PCC_CFG_ADDR);
    assign cfgWrite = sfrWrite && cfgHit;

    // The counter counts up, so bit N-1 falling marks the low N bits
    // wrapping to zero. Watching the fall of the stored copy against the
    // live value also copes with a counter that pauses between steps.
    // Only bits 10 to 7 matter here; the rest feed the outside comparators.
    assign watchedBits = counterValue[`PCC_WATCH_MSB:`PCC_WATCH_LSB];
    assign watchedFalls = watchedBitsPrev & ~watchedBits;
    assign cycleWrap = watchedFalls[cycleLengthSelect];

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            watchedBitsPrev <= 4'h0;
        end else begin
            watchedBitsPrev <= watchedBits;
        end
    end

    // Configuration register: the unused field has no storage at all.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            reloadBankSelect <= 1'b0;
            cycleOverflowIrqEnable <= 1'b0;
            cycleLengthSelect <= `PCC_LEN_8;
        end else if (cfgWrite) begin
            reloadBankSelect <= sfrWriteData[`PCC_BIT_BANK_SEL];
            cycleOverflowIrqEnable <= sfrWriteData[`PCC_BIT_IRQ_EN];
            cycleLengthSelect <=
                sfrWriteData[`PCC_LEN_MSB:`PCC_LEN_LSB];
        end
    end

    // A hardware overflow in the same cycle as a software clear still
    // leaves the flag set, so no cycle end is ever missed.
    always @* begin
        next_flag = cycleOverflowFlag;
        if (cfgWrite) begin
            next_flag = sfrWriteData[`PCC_BIT_FLAG];
        end
        if (cycleWrap) begin
            next_flag = 1'b1;
        end
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cycleOverflowFlag <= 1'b0;
            cycleOverflowPulse <= 1'b0;
            irqRequest <= 1'b0;
        end else begin
            cycleOverflowFlag <= next_flag;
            cycleOverflowPulse <= cycleWrap;
            // The stored enable is used, so a request follows an enable
            // write one cycle late; the flag itself is never lost.
            irqRequest <= next_flag && cycleOverflowIrqEnable;
        end
    end

    assign cfgReadValue = {reloadBankSelect, cycleOverflowIrqEnable,
        cycleOverflowFlag, `PCC_UNUSED_READ, cycleLengthSelect};

    genvar g;
    generate
        for (g = 0; g < `PCC_SLOTS; g = g + 1) begin : slot
            // A sized copy of the loop index keeps the slot argument exact.
            localparam [1:0] slotIndex = g;

            assign lowHits[g] = slotHit(sfrAddr, `PCC_LOW_BASE, slotIndex);
            assign highHits[g] = slotHit(sfrAddr, `PCC_HIGH_BASE, slotIndex);
            // Only narrow PWM channels longer than 8 bits ever take the
            // shadow; in any other mode it is storage software alone sees.
            assign reloadNow[g] = cycleWrap && pwmEnable[g]
                && !widePwmEnable[g]
                && (cycleLengthSelect != `PCC_LEN_8);

            pcc_reload_slot slotRegs (
                .clock(clock),
                .reset(reset),
                .writeLow(sfrWrite && lowHits[g]),
                .writeHigh(sfrWrite && highHits[g]),
                .bankSel(reloadBankSelect),
                .writeData(sfrWriteData),
                .reloadNow(reloadNow[g]),
                .compareValue(compareValues[16*g+15:16*g]),
                .reloadValue(reloadValues[16*g+15:16*g])
            );
        end
    endgenerate

    // Period top seen by each channel's comparator.
    always @* begin
        next_cycleTops = cycleTops;
        for (i = 0; i < `PCC_SLOTS; i = i + 1) begin
            if (widePwmEnable[i]) begin
                next_cycleTops[16*i +: 16] = `PCC_TOP_16;
            end else begin
                next_cycleTops[16*i +: 16] =
                    lengthTop(cycleLengthSelect);
            end
        end
    end

    // Read path: the bank select steers compare-byte reads too.
    always @* begin
        next_readData = `PCC_BYTE_ZERO;
        if (sfrRead) begin
            if (cfgHit) begin
                next_readData = cfgReadValue;
            end
            for (j = 0; j < `PCC_SLOTS; j = j + 1) begin
                if (lowHits[j]) begin
                    next_readData = reloadBankSelect
                        ? reloadValues[16*j +: 8]
                        : compareValues[16*j +: 8];
                end
                if (highHits[j]) begin
                    next_readData = reloadBankSelect
                        ? reloadValues[16*j+8 +: 8]
                        : compareValues[16*j+8 +: 8];
                end
            end
        end
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            sfrReadData <= `PCC_BYTE_ZERO;
            cycleTops <= {`PCC_SLOTS{`PCC_TOP_8}};
        end else begin
            sfrReadData <= next_readData;
            cycleTops <= next_cycleTops;
        end
    end

endmodule

`default_nettype wire

// ---- sim/pcc_cycle_config_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcc_cycle_config_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWriteData,
    input wire logic [7:0] sfrReadData,
    input wire logic [15:0] counterValue,
    input wire logic [2:0] widePwmEnable,
    input wire logic [47:0] cycleTops,
    input wire logic cycleOverflowFlag,
    input wire logic cycleOverflowPulse,
    input wire logic irqRequest
);
    // Length select and interrupt enable are tracked from the bus writes,
    // so the watched bit follows the register, not the registered tops.
    wire cfgWrite = sfrWrite && sfrAddr == 8'ha1;
    wire [3:0] nowBits = counterValue[10:7];
    reg [3:0] lastBits;
    reg [1:0] lenShadow;
    reg irqEnShadow;
    wire wrap = lastBits[lenShadow] && !nowBits[lenShadow];
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            lastBits <= 4'h0;
            lenShadow <= 2'h0;
            irqEnShadow <= 1'b0;
        end else begin
            lastBits <= nowBits;
            if (cfgWrite) begin
                lenShadow <= sfrWriteData[1:0];
                irqEnShadow <= sfrWriteData[6];
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_cfg_unused: assert property (
        sfrRead && sfrAddr == 8'ha1 |=> sfrReadData[4:2] == 3'h0)
        else $error("unused config bits not zero");
    a_flag_sticky: assert property (
        cycleOverflowFlag && !cfgWrite |=> cycleOverflowFlag)
        else $error("flag cleared by hardware");
    a_flag_clear: assert property (
        cfgWrite && !sfrWriteData[5] && !wrap |=> !cycleOverflowFlag)
        else $error("flag not cleared by software");
    a_flag_swset: assert property (
        cfgWrite && sfrWriteData[5] |=> cycleOverflowFlag)
        else $error("flag not set by software");
    a_wrap_pulse: assert property (
        wrap |=> cycleOverflowPulse && cycleOverflowFlag)
        else $error("watched bit wrap missed");
    a_pulse_single: assert property (
        cycleOverflowPulse |=> !cycleOverflowPulse)
        else $error("pulse longer than one cycle");
    a_irq_gate: assert property (
        irqRequest == (cycleOverflowFlag && $past(irqEnShadow)))
        else $error("interrupt not gated by flag and enable");
    a_wide_top: assert property (
        widePwmEnable[1] |=> cycleTops[31:16] == 16'hffff)
        else $error("wide slot top wrong");
    a_top_shared: assert property (
        !widePwmEnable[2] && !widePwmEnable[0]
        |=> cycleTops[47:32] == cycleTops[15:0])
        else $error("narrow slots differ in length");
    c_wrap: cover property (cycleOverflowPulse);
    c_irq: cover property (irqRequest);
    c_wide: cover property (cycleTops[31:16] == 16'hffff);
endmodule
bind pcc_cycle_config pcc_cycle_config_properties u_props (.clock, .reset,
    .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData, .sfrReadData, .counterValue,
    .widePwmEnable, .cycleTops, .cycleOverflowFlag, .cycleOverflowPulse,
    .irqRequest);
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic [7:0] sfrWriteData = 8'h00;
    logic [15:0] counterValue = 16'h0000;
    logic [2:0] pwmEnable = 3'h7;
    logic [2:0] widePwmEnable = 3'h2;
    wire [7:0] sfrReadData;
    wire [47:0] compareValues;
    wire [47:0] cycleTops;
    wire cycleOverflowFlag;
    wire cycleOverflowPulse;
    wire irqRequest;
    int failures = 0;
    int n_compared = 0;
    logic [15:0] tops [4] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h07ff};
    always #25 clock = ~clock;
    pcc_cycle_config dut (.clock, .reset, .sfrAddr, .sfrWrite, .sfrRead,
        .sfrWriteData, .sfrReadData, .counterValue, .pwmEnable,
        .widePwmEnable, .compareValues, .cycleTops, .cycleOverflowFlag,
        .cycleOverflowPulse, .irqRequest);
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfrAddr = a;
        sfrWrite = 1'b1;
        sfrWriteData = d;
        @(negedge clock);
        sfrWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(negedge clock);
        sfrRead = 1'b0;
        chk(sfrReadData, e);
    endtask
    // One edge after a step the flag and pulse of a wrap are visible.
    task automatic step(input logic [15:0] v);
        @(negedge clock);
        counterValue = v;
        @(negedge clock);
    endtask
    task automatic complete_run;
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (10) @(negedge clock);
        reset = 1'b0;
        chk(cycleTops, 48'h00ff00ff00ff);
        rd(8'ha1, 8'h00);
        for (int l = 0; l < 4; l++) begin
            step(16'h0000);
            wr(8'ha1, {6'h10, l[1:0]});
            rd(8'ha1, {6'h10, l[1:0]});
            chk(cycleTops, {tops[l], 16'hffff, tops[l]});
            step(tops[l] >> 1);
            step((tops[l] >> 1) + 16'h1);
            chk(cycleOverflowFlag, 1'b0);
            step(tops[l]);
            step(tops[l] + 16'h1);
            chk(cycleOverflowPulse, 1'b1);
            chk(cycleOverflowFlag, 1'b1);
            chk(irqRequest, 1'b1);
        end
        wr(8'ha1, 8'h03);
        wr(8'ha1, 8'h20);
        chk(irqRequest, 1'b0);
        rd(8'ha1, 8'h20);
        wr(8'ha1, 8'hdc);
        rd(8'ha1, 8'hc0);
        chk(irqRequest, 1'b0);
        wr(8'ha1, 8'h01);
        wr(8'hf0, 8'h34);
        wr(8'hf1, 8'h12);
        chk(compareValues[15:0], 16'h1234);
        rd(8'hf1, 8'h12);
        wr(8'ha1, 8'h81);
        wr(8'hf0, 8'h78);
        wr(8'hf1, 8'h56);
        wr(8'hf2, 8'hbc);
        wr(8'hf3, 8'h9a);
        wr(8'hf4, 8'hf0);
        wr(8'hf5, 8'hde);
        chk(compareValues, 48'h000000001234);
        rd(8'hf0, 8'h78);
        step(16'h0000);
        step(16'h01ff);
        step(16'h0200);
        chk(compareValues, 48'hdef000005678);
        wr(8'ha1, 8'h80);
        wr(8'hf1, 8'hee);
        step(16'h0000);
        step(16'h00ff);
        step(16'h0100);
        chk(compareValues[15:0], 16'h5678);
        pwmEnable = 3'h6;
        wr(8'ha1, 8'h81);
        step(16'h0000);
        chk(compareValues, 48'hdef000005678);
        complete_run();
    end
endmodule
`default_nettype wire
